// File: idata_pkg.sv
package idata_pkg;

  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          RAM_BYTES   = 256;
  localparam int          SFR_BYTES   = 128;
  localparam logic [7:0]  UPPER_BASE  = 8'h80;
  localparam logic [7:0]  BANK_TOP    = 8'h1F;
  localparam logic [7:0]  BITB_BASE   = 8'h20;
  localparam logic [7:0]  BITB_TOP    = 8'h2F;
  localparam int          BANK_BYTES  = 8;
  localparam int          BIT_POS_W   = 3;
  localparam int          BIT_BYTE_LSB = 3;
  localparam int          BIT_BYTE_MSB = 6;
  localparam int          BANK_LSB    = 3;
  localparam int          BANK_MSB    = 4;
  localparam int          BANK_SEL_W  = 2;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_BYTE,
    OP_BIT
  } op_t;

endpackage

// File: idata_decoder.sv
// Function
// - Internal data RAM holds 256 bytes addressed by an 8-bit operand address from the core.
// - An indirect access to an upper-half address reaches the upper 128 bytes of RAM.
// - A direct byte access or bit read to an upper-half address reaches the 128-byte special-register space instead of RAM; a bit write writes neither.
// - A lower-half address always reaches RAM, in direct or indirect mode.
// - The lowest 32 bytes of RAM form four banks of eight working registers.
// - The 16 bytes after the banks are reachable as whole bytes and as single bits.
`timescale 1ns/1ps

module idata_decoder
  import idata_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_BYTES
)
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              REQ,
  input  wire logic              WE,
  input  wire logic              INDIRECT,
  input  wire logic              BIT_OP,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WBIT,
  input  wire logic [DATA_W-1:0] SFR_RDATA,
  output logic                   ACK,
  output logic      [DATA_W-1:0] RDATA,
  output logic                   RBIT,
  output logic                   SFR_SEL,
  output logic                   SFR_WE,
  output logic      [ADDR_W-1:0] SFR_ADDR,
  output logic      [DATA_W-1:0] SFR_WDATA,
  output logic                   IS_BANK_REG,
  output logic      [1:0]        BANK_NUM
);

  // ==========================================================================
  // Types and storage
  // ==========================================================================

  typedef struct packed {
    logic                  ack;
    logic [DATA_W-1:0]     rdata;
    logic                  rbit;
    logic                  sfr_sel;
    logic                  sfr_we;
    logic [ADDR_W-1:0]     sfr_addr;
    logic [DATA_W-1:0]     sfr_wdata;
    logic                  is_bank;
    logic [BANK_SEL_W-1:0] bank;
    op_t                   pend;
    logic [BIT_POS_W-1:0]  bitpos;
  } state_t;

  state_t            s_q;
  state_t            s_d;

  // Byte storage for the whole internal data space; its contents are not reset.
  logic [DATA_W-1:0] ram [RAM_DEPTH];

  // ==========================================================================
  // Address helpers
  // ==========================================================================

  // True for addresses in the dual-mapped upper half.
  function automatic logic is_upper(
    input logic [ADDR_W-1:0] a
  );
    is_upper = a >= UPPER_BASE;
  endfunction

  // Position of the addressed bit inside its byte.
  function automatic logic [BIT_POS_W-1:0] bit_pos(
    input logic [ADDR_W-1:0] a
  );
    bit_pos = a[BIT_POS_W-1:0];
  endfunction

  // Bit addresses below the upper half map into the bit-addressable bytes.
  function automatic logic [ADDR_W-1:0] bit_byte(
    input logic [ADDR_W-1:0] a
  );
    bit_byte = BITB_BASE + ADDR_W'(a[BIT_BYTE_MSB:BIT_BYTE_LSB]);
  endfunction

  // Bit addresses in the upper half name the register whose low address bits are clear.
  function automatic logic [ADDR_W-1:0] bit_reg(
    input logic [ADDR_W-1:0] a
  );
    bit_reg = {a[ADDR_W-1:BIT_POS_W], {BIT_POS_W{1'h0}}};
  endfunction

  // True for bytes that belong to the working-register banks.
  function automatic logic in_banks(
    input logic [ADDR_W-1:0] a
  );
    in_banks = a <= BANK_TOP;
  endfunction

  // Bank number of a byte inside the bank area.
  function automatic logic [BANK_SEL_W-1:0] bank_of(
    input logic [ADDR_W-1:0] a
  );
    bank_of = a[BANK_MSB:BANK_LSB];
  endfunction

  function automatic logic pick_bit(
    input logic [DATA_W-1:0]    d,
    input logic [BIT_POS_W-1:0] p
  );
    pick_bit = d[p];
  endfunction

  function automatic logic [DATA_W-1:0] put_bit(
    input logic [DATA_W-1:0]    d,
    input logic [BIT_POS_W-1:0] p,
    input logic                 v
  );
    put_bit    = d;
    put_bit[p] = v;
  endfunction

  // ==========================================================================
  // Decode
  // ==========================================================================

  logic              upper;
  logic              to_sfr;
  logic [ADDR_W-1:0] ram_addr;
  logic [DATA_W-1:0] ram_rd;
  logic [DATA_W-1:0] ram_wr;
  logic              ram_we;

  // Indirect upper accesses stay in RAM; direct ones leave for the register space.
  always_comb begin
    upper  = is_upper(ADDR);
    to_sfr = upper && !INDIRECT;
  end

  // Bit operations in the lower half are folded onto their byte.
  always_comb begin
    if (BIT_OP && !upper) begin
      ram_addr = bit_byte(ADDR);
    end else begin
      ram_addr = ADDR;
    end
  end

  always_comb begin
    ram_rd = ram[ram_addr];
  end

  // Bit writes are a read-modify-write of the addressed byte within one cycle.
  always_comb begin
    if (BIT_OP) begin
      ram_wr = put_bit(ram_rd, bit_pos(ADDR), WBIT);
    end else begin
      ram_wr = WDATA;
    end
    ram_we = REQ && WE && !to_sfr;
  end

  always_ff @(posedge SYS_CLK) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wr;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================

  always_comb begin
    s_d         = s_q;
    s_d.ack     = REQ;
    s_d.sfr_sel = REQ && to_sfr;
    s_d.sfr_we  = REQ && to_sfr && WE && !BIT_OP;
    s_d.pend    = OP_NONE;
    if (REQ) begin
      s_d.sfr_wdata = WDATA;
      s_d.is_bank   = in_banks(ram_addr) && !to_sfr;
      s_d.bank      = bank_of(ram_addr);
      s_d.bitpos    = bit_pos(ADDR);
      if (to_sfr) begin
        if (BIT_OP) begin
          s_d.sfr_addr = bit_reg(ADDR);
        end else begin
          s_d.sfr_addr = ADDR;
        end
        // Only reads wait for data from the register space.
        if (!WE) begin
          s_d.pend = BIT_OP ? OP_BIT : OP_BYTE;
        end
      end else begin
        s_d.sfr_addr = ADDR;
        s_d.rdata    = ram_rd;
        s_d.rbit     = pick_bit(ram_rd, bit_pos(ADDR));
      end
    end
    // Register reads return on the cycle after the select, so a returning
    // read takes priority over a RAM read issued in the same cycle.
    case (s_q.pend)
      OP_BYTE, OP_BIT: begin
        s_d.rdata = SFR_RDATA;
        s_d.rbit  = pick_bit(SFR_RDATA, s_q.bitpos);
      end
      default: begin
        s_d.pend = s_d.pend;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================

  assign ACK         = s_q.ack;
  assign RDATA       = s_q.rdata;
  assign RBIT        = s_q.rbit;
  assign SFR_SEL     = s_q.sfr_sel;
  assign SFR_WE      = s_q.sfr_we;
  assign SFR_ADDR    = s_q.sfr_addr;
  assign SFR_WDATA   = s_q.sfr_wdata;
  assign IS_BANK_REG = s_q.is_bank;
  assign BANK_NUM    = s_q.bank;

endmodule

// File: idata_decoder_assertions.sv
`timescale 1ns/1ps
module idata_decoder_chk(input wire logic SYS_CLK, RST_N, REQ, WE, INDIRECT, BIT_OP, ACK, SFR_SEL, SFR_WE, IS_BANK_REG,
  input wire logic [7:0] ADDR, SFR_ADDR, input wire logic [1:0] BANK_NUM);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_ack_after_req: assert property (REQ |=> ACK) else $error("ack missing");
  a_ack_no_req: assert property (!REQ |=> !ACK) else $error("stray ack");
  a_ind_upper_ram: assert property (REQ && INDIRECT |=> !SFR_SEL) else $error("sfr on indirect");
  a_dir_upper_sfr: assert property (REQ && !INDIRECT && !BIT_OP && ADDR[7] |=> SFR_SEL && SFR_ADDR == $past(ADDR))
    else $error("sfr byte missed");
  a_lower_ram: assert property (REQ && !ADDR[7] |=> !SFR_SEL) else $error("sfr on lower");
  a_bank_status: assert property (REQ && !BIT_OP && ADDR < 8'h20 |=> IS_BANK_REG && BANK_NUM == $past(ADDR[4:3]))
    else $error("bank wrong");
  a_bit_area: assert property (REQ && !BIT_OP && ADDR[7:4] == 4'h2 |=> !IS_BANK_REG && !SFR_SEL)
    else $error("bit area wrong");
  a_bit_sfr: assert property (REQ && BIT_OP && !INDIRECT && ADDR[7] |=> SFR_SEL && SFR_ADDR == {$past(ADDR[7:3]), 3'h0})
    else $error("sfr bit wrong");
  a_bit_lower_ram: assert property (REQ && BIT_OP && !ADDR[7] |=> !SFR_SEL && !IS_BANK_REG)
    else $error("lower bit left ram");
  a_sfr_byte_we: assert property (REQ && WE && !INDIRECT && !BIT_OP && ADDR[7] |=> SFR_WE)
    else $error("sfr write missed");
  a_sfr_we_sel: assert property (SFR_WE |-> SFR_SEL) else $error("sfr write without select");
endmodule
bind idata_decoder idata_decoder_chk i_chk(.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REQ(REQ), .WE(WE), .INDIRECT(INDIRECT),
  .BIT_OP(BIT_OP), .ACK(ACK), .SFR_SEL(SFR_SEL), .SFR_WE(SFR_WE), .IS_BANK_REG(IS_BANK_REG), .ADDR(ADDR),
  .SFR_ADDR(SFR_ADDR),
  .BANK_NUM(BANK_NUM));

// File: sfr_model.sv
`timescale 1ns/1ps
module sfr_model(input wire logic SYS_CLK, SFR_SEL, input wire logic [7:0] SFR_ADDR, output logic [7:0] SFR_RDATA);
  logic [7:0] junk_q = 8'h00;
  always_ff @(posedge SYS_CLK) junk_q <= junk_q + 8'h5B;
  // Answers with the inverted address when selected and with a moving pattern otherwise.
  assign SFR_RDATA = SFR_SEL ? ~SFR_ADDR : junk_q;
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       SYS_CLK = 0, RST_N = 0, REQ = 0, WE = 0, INDIRECT = 0, BIT_OP = 0, WBIT = 0;
  logic [7:0] ADDR = 0, WDATA = 0, SFR_RDATA, RDATA, SFR_ADDR, SFR_WDATA;
  logic       ACK, RBIT, SFR_SEL, SFR_WE, IS_BANK_REG;
  logic [1:0] BANK_NUM;
  int         n_errors = 0, n_tests = 0, cyc = 0;
  idata_decoder i_dut(.*);
  sfr_model i_sfr(.SYS_CLK(SYS_CLK), .SFR_SEL(SFR_SEL), .SFR_ADDR(SFR_ADDR), .SFR_RDATA(SFR_RDATA));
  initial forever #5 SYS_CLK = ~SYS_CLK;
  task chk(input string n, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task acc(input logic w, ind, bo, input logic [7:0] a, d, input logic b);
    @(posedge SYS_CLK);
    {REQ, WE, INDIRECT, BIT_OP, ADDR, WDATA, WBIT} <= {1'b1, w, ind, bo, a, d, b};
    @(posedge SYS_CLK);
    REQ <= 1'b0;
    #1;
  endtask
  task t_map;
    acc(1, 0, 0, 8'h30, 8'hA5, 0);
    acc(0, 1, 0, 8'h30, 0, 0);
    chk("rdata lo", RDATA, 8'hA5);
    acc(1, 1, 0, 8'h90, 8'h3C, 0);
    acc(0, 0, 0, 8'h90, 0, 0);
    chk("sfr sel", SFR_SEL, 8'h01);
    @(posedge SYS_CLK);
    #1 chk("sfr rd", RDATA, 8'h6F);
    acc(0, 1, 0, 8'h90, 0, 0);
    chk("rdata hi", RDATA, 8'h3C);
    acc(1, 0, 0, 8'h90, 8'h5A, 0);
    chk("ack", ACK, 8'h01);
    chk("sfr we", SFR_WE, 8'h01);
    chk("sfr wdata", SFR_WDATA, 8'h5A);
    acc(0, 1, 0, 8'h90, 0, 0);
    chk("ram kept", RDATA, 8'h3C);
    $display("t_map done");
  endtask
  task t_bits;
    acc(1, 0, 0, 8'h21, 8'h00, 0);
    acc(1, 0, 1, 8'h0D, 0, 1);
    acc(0, 0, 0, 8'h21, 0, 0);
    chk("bit byte", RDATA, 8'h20);
    acc(0, 0, 1, 8'h0D, 0, 0);
    chk("rbit", RBIT, 8'h01);
    acc(0, 1, 0, 8'h1B, 0, 0);
    chk("bank", {IS_BANK_REG, BANK_NUM}, 8'h07);
    acc(0, 0, 1, 8'h93, 0, 0);
    chk("sfr bit addr", SFR_ADDR, 8'h90);
    @(posedge SYS_CLK);
    #1 chk("sfr rbit", RBIT, 8'h01);
    $display("t_bits done");
  endtask
  task end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge SYS_CLK) if (++cyc == 2000) begin
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_map;
    t_bits;
    end_sim;
  end
endmodule
